// ---- dv/sbt_tester.sv ----
// sbt_tester: behavioural board tester that drives the serial test link.
// assumes: the port samples on tck rise and drives tdo on tck fall.
`timescale 1ns/10ps
module sbt_tester
    import sbt_pkg::*;
(
    output logic      tck_out,    // test clock, still between frames
    output logic      tms_out,    // mode select
    output logic      tdi_out,    // serial data to the port
    input  wire logic tdo_in,     // serial data from the port
    input  wire logic tdo_oe_in   // port drives tdo
);
    // ------------------------------------------------------------------
    // link state
    // ------------------------------------------------------------------
    int   oe_miss = 0;    // shift samples taken with tdo undriven
    logic last    = 1'b0; // last bit seen
    logic oe_seen;        // enable seen at the last sample

    // clock parked low; the pulled-up lines idle high
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end

    // one 64 ns tck period; tdo is read just before the rise
    task automatic step(input logic tms, input logic tdi, output logic seen);
        #1;
        tms_out = tms;
        tdi_out = tdi;
        #31;
        oe_seen = tdo_oe_in;
        // undriven line must not look like the stale bit
        seen    = tdo_oe_in ? tdo_in : ~last;
        last    = seen;
        tck_out = 1'b1;
        #32;
        tck_out = 1'b0;
    endtask : step

    // n periods at a fixed mode select, data held high
    task automatic clocks(input int n, input logic tms);
        logic b;
        for (int i = 0; i < n; i++) begin
            step(tms, 1'b1, b);
        end
    endtask : clocks

    // five high edges force the controller home, then park in idle
    task automatic tap_reset();
        clocks(5, 1'b1);
        clocks(1, 1'b0);
    endtask : tap_reset

    // full scan from idle back to idle; lsb out first, msb in last
    task automatic scan(input logic ir, input int n, input logic [BSR_W-1:0] din,
                        output logic [BSR_W-1:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b1, b);          // select data column
        if (ir) begin
            step(1'b1, 1'b1, b);      // select instruction column
        end
        step(1'b0, 1'b1, b);          // capture
        step(1'b0, 1'b1, b);          // enter shift
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
            if (oe_seen !== 1'b1) begin
                oe_miss++;
            end
        end
        step(1'b1, 1'b1, b);          // update makes it take effect
        step(1'b0, 1'b1, b);          // back to idle
    endtask : scan
endmodule : sbt_tester

// ---- dv/testbench.sv ----
// testbench: drives the test port through the tester model and checks it.
// assumes: sbt_pkg and sbt_tap compiled first; tester model in dv/.
`timescale 1ns/10ps
module testbench;
    import sbt_pkg::*;
    // ------------------------------------------------------------------
    // constants and signals
    // ------------------------------------------------------------------
    localparam logic [2:0]       REV     = 3'h5;      // arbitrary value
    localparam logic [16:0]      PART    = 17'h1c3a5; // arbitrary value
    localparam logic [10:0]      VEND    = 11'h2b3;   // arbitrary value
    localparam logic [BSR_W-1:0] ID_EXP  = BSR_W'({REV, PART, VEND, ID_PRESENT});
    localparam logic [BSR_W-1:0] PAT_A   = 109'h05a5a5a5a5a5a5a5a5a5a5a5a5a5;
    localparam logic [BSR_W-1:0] PAT_B   = ~PAT_A;
    localparam logic [BSR_W-1:0] PRE_ON  = 109'h13c3c3c3c3c3c3c3c3c3c3c3c3c3;
    localparam logic [BSR_W-1:0] PRE_OFF = 109'h0c3c3c3c3c3c3c3c3c3c3c3c3c3c;
    localparam logic [BSR_W-1:0] PRE_CLR = 109'h03c3c3c3c3c3c3c3c3c3c3c3c3c3;
    localparam int               LIMIT   = 20000;     // tests need about 4100

    logic             clock_in, reset_in, tck, tms, tdi, tdo, tdo_oe, extest, q_bus_oe;
    logic [BSR_W-1:0] ring_in, ring_out, got;
    int               errors = 0;
    int               checked = 0;
    int               cycles = 0;

    sbt_tap #(.REV_ID(REV), .PART_ID(PART), .VENDOR_ID(VEND)) u_dut (
        .clock_in(clock_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .ring_in(ring_in),
        .ring_out(ring_out), .extest_out(extest), .q_bus_oe_out(q_bus_oe));

    sbt_tester u_tester (
        .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));

    // memory clock, 100 MHz
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // hang guard; a hang counts as a mismatch
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [BSR_W-1:0] seen, input logic [BSR_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // legal codes only; the capture pattern comes back in got
    task automatic load_ir(input logic [IR_W-1:0] code);
        u_tester.scan(1'b1, IR_W, BSR_W'(code), got);
        check(got, BSR_W'(IR_CAPTURE));
    endtask : load_ir

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        reset_in = 1'b1;
        ring_in  = PAT_A;
        // tck must run so the reset reaches the test side (four test clocks)
        u_tester.clocks(4, 1'b1);
        @(posedge clock_in) #1 reset_in = 1'b0;
        // two sync rises and one more at home, then one low step to
        // idle, since every scan starts from idle
        u_tester.clocks(3, 1'b1);
        u_tester.clocks(1, 1'b0);
        check(BSR_W'(tdo_oe), BSR_W'(1'b0));
        check(ring_out, '0);
        check(BSR_W'({extest, q_bus_oe}), BSR_W'(2'h1));
        u_tester.scan(1'b0, ID_W, '1, got);
        check(got, ID_EXP);
        $display("test power-up identify done");

        load_ir(IR_BYPASS);
        u_tester.scan(1'b0, 4, 109'hb, got);
        check(got, 109'h6);
        $display("test bypass done");

        load_ir(IR_SAMPLE);
        u_tester.scan(1'b0, BSR_W, PRE_ON, got);
        check(got, PAT_A);
        check(ring_out, PRE_ON);
        check(BSR_W'({extest, q_bus_oe}), BSR_W'(2'h1));
        $display("test sample preload done");

        @(posedge clock_in) #1 ring_in = PAT_B;
        load_ir(IR_SAMPLEZ);
        check(BSR_W'(q_bus_oe), BSR_W'(1'b0));
        u_tester.scan(1'b0, BSR_W, PRE_ON, got);
        check(got, PAT_B);
        check(BSR_W'(q_bus_oe), BSR_W'(1'b0));
        $display("test sample high-z done");

        load_ir(IR_EXTEST);
        check(BSR_W'({extest, q_bus_oe}), BSR_W'(2'h3));
        u_tester.scan(1'b0, BSR_W, PRE_OFF, got);
        check(got, PAT_B);
        check(ring_out, PRE_OFF);
        check(BSR_W'(q_bus_oe), BSR_W'(1'b0));
        u_tester.scan(1'b0, BSR_W, PRE_ON, got);
        check(BSR_W'(q_bus_oe), BSR_W'(1'b1));
        $display("test external drive done");

        u_tester.tap_reset();
        check(ring_out, PRE_CLR);
        check(BSR_W'({extest, q_bus_oe}), BSR_W'(2'h1));
        u_tester.scan(1'b0, ID_W, '0, got);
        check(got, ID_EXP);
        load_ir(IR_IDCODE);
        u_tester.scan(1'b0, ID_W, '0, got);
        check(got, ID_EXP);
        check(BSR_W'(tdo_oe), BSR_W'(1'b0));
        check(BSR_W'(u_tester.oe_miss), '0);
        $display("test link reset done");
        conclude();
    end
endmodule : testbench

// ---- hw/sbt_pkg.sv ----
// sbt_pkg: constants and types of the boundary-scan test port.
// assumes: one test port per device, one pin ring, 3-bit instructions.
package sbt_pkg;

    // ------------------------------------------------------------------
    // widths and cell positions
    // ------------------------------------------------------------------
    localparam int IR_W    = 3;     // instruction width
    localparam int ID_W    = 32;    // identification word width
    localparam int BSR_W   = 109;   // boundary ring length
    localparam int OE_CELL = 108;   // output-bus enable cell

    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;   // drive preload
    localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;   // identify
    localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;   // sample, bus off
    localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;   // sample/preload
    localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;   // one-bit path
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;   // fault-isolation 01

    // ------------------------------------------------------------------
    // identification word pieces
    // ------------------------------------------------------------------
    localparam int   REV_W      = 3;      // revision field, top bits
    localparam int   PART_W     = 17;     // part field
    localparam int   VEND_W     = 11;     // vendor field, above bit 0
    localparam logic ID_PRESENT = 1'h1;   // bit 0 marks the word present

    // ------------------------------------------------------------------
    // controller states and scan paths
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR    = 4'hf, ST_RTI    = 4'hc, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
        ST_SH_DR  = 4'h2, ST_EX1_DR = 4'h1, ST_PAU_DR = 4'h3, ST_EX2_DR = 4'h0,
        ST_UPD_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'he, ST_SH_IR  = 4'ha,
        ST_EX1_IR = 4'h9, ST_PAU_IR = 4'hb, ST_EX2_IR = 4'h8, ST_UPD_IR = 4'hd
    } sbt_state_t;

    typedef enum logic [1:0] {
        PATH_BYP = 2'h0,   // bypass cell
        PATH_ID  = 2'h1,   // identification word
        PATH_BSR = 2'h2    // boundary ring
    } sbt_path_t;

endpackage : sbt_pkg

// ---- hw/sbt_tap.sv ----
// sbt_tap: boundary-scan test port of the memory, with its pin ring.
// assumes: tck_in comes from the board tester and may stand still;
// ring_in carries the live pin values; ring_out feeds the pad muxes.
`timescale 1ns/10ps

module sbt_tap
    import sbt_pkg::*;
#(
    parameter logic [REV_W-1:0]  REV_ID    = 3'h0,     // arbitrary value
    parameter logic [PART_W-1:0] PART_ID   = 17'h00a5, // arbitrary value
    parameter logic [VEND_W-1:0] VENDOR_ID = 11'h05a   // arbitrary value
) (
    input  wire logic             clock_in,     // memory clock
    input  wire logic             reset_in,     // sync reset, high
    input  wire logic             tck_in,       // test clock
    input  wire logic             tms_in,       // mode select pad
    input  wire logic             tdi_in,       // serial data pad
    output logic                  tdo_out,      // serial data out
    output logic                  tdo_oe_out,   // data out enable
    input  wire logic [BSR_W-1:0] ring_in,      // live pin values
    output logic      [BSR_W-1:0] ring_out,     // preload latches
    output logic                  extest_out,   // pads take ring_out
    output logic                  q_bus_oe_out  // output bus enable
);

    // ------------------------------------------------------------------
    // state of the test-clock side
    // ------------------------------------------------------------------
    // everything here moves on the rising test clock; the synchroniser
    // stages sit in the same struct so one register process owns them
    typedef struct packed {
        sbt_state_t       st;     // controller state
        logic [IR_W-1:0]  ir_sh;  // instruction shift stage
        logic [IR_W-1:0]  ir;     // active instruction
        logic             byp;    // bypass cell
        logic [ID_W-1:0]  id_sh;  // identification shifter
        logic [BSR_W-1:0] bsr;    // ring shift stage
        logic [BSR_W-1:0] pre;    // ring preload latches
        logic             rst1;   // reset sync, first
        logic             rst2;   // reset sync, second
        logic [BSR_W-1:0] ring1;  // pin sync, first
        logic [BSR_W-1:0] ring2;  // pin sync, second
        logic             hiz;    // bus forced off
        logic             ext;    // external test active
    } sbt_tck_t;

    // state of the memory-clock side
    // only two levels cross; each changes at most once per instruction
    // or ring update, so two flops apiece suffice and no handshake is used
    typedef struct packed {
        logic [1:0] s1;    // {ext,hiz} sync, first
        logic [1:0] s2;    // {ext,hiz} sync, second
        logic       q_oe;  // bus enable
        logic       ext;   // external test
    } sbt_sys_t;

    sbt_tck_t r;        // test-clock registers
    sbt_tck_t next_r;   // their next value
    sbt_sys_t s;        // memory-clock registers
    sbt_sys_t next_s;   // their next value
    logic     tdo_q;    // falling-edge data
    logic     oe_q;     // falling-edge enable
    logic     dr_bit;   // lsb of chosen data path

    // identify word, fixed: revision, part, vendor, then the presence one
    localparam logic [ID_W-1:0] ID_WORD = {REV_ID, PART_ID, VENDOR_ID, ID_PRESENT};

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // controller walk, one step per rising edge
    // five ones lead home from any state, which is what lets the
    // mode-select line alone reset the port without a reset pin
    function automatic sbt_state_t tap_next(sbt_state_t c, logic m);
        case (c)
            ST_TLR:    tap_next = m ? ST_TLR    : ST_RTI;
            ST_RTI:    tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = m ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
            default:   tap_next = ST_TLR;
        endcase
    endfunction : tap_next

    // which register sits between data in and data out
    // a bad code must still give a defined one-bit path, so the tester
    // sees a known chain length even after a wrong load
    function automatic sbt_path_t path_of(logic [IR_W-1:0] i);
        case (i)
            IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE: path_of = PATH_BSR;
            IR_IDCODE: path_of = PATH_ID;
            // reserved codes fall back to bypass
            default:   path_of = PATH_BYP;
        endcase
    endfunction : path_of

    // ------------------------------------------------------------------
    // test-clock side, next state
    // ------------------------------------------------------------------
    // pads pull tms/tdi high, so a floating port walks into reset
    // capture and update act on the edge that enters their state, so the
    // new value is already there while the controller sits in it
    always_comb begin
        next_r       = r;
        next_r.rst1  = reset_in;
        next_r.rst2  = r.rst1;
        next_r.ring1 = ring_in;
        next_r.ring2 = r.ring1;
        next_r.st    = tap_next(r.st, tms_in);
        // instruction shift, msb in, lsb out
        if (r.st == ST_SH_IR) begin
            next_r.ir_sh = {tdi_in, r.ir_sh[IR_W-1:1]};
        end
        if (next_r.st == ST_CAP_IR) begin
            next_r.ir_sh = IR_CAPTURE;
        end
        // shifted instruction taken only on entry to update
        if (next_r.st == ST_UPD_IR) begin
            next_r.ir = r.ir_sh;
        end
        // data shift on the one selected path
        if (r.st == ST_SH_DR) begin
            case (path_of(r.ir))
                PATH_BSR: next_r.bsr   = {tdi_in, r.bsr[BSR_W-1:1]};
                PATH_ID:  next_r.id_sh = {tdi_in, r.id_sh[ID_W-1:1]};
                default:  next_r.byp   = tdi_in;
            endcase
        end
        // capture: snapshot only, memory logic never sees it
        if (next_r.st == ST_CAP_DR) begin
            case (path_of(r.ir))
                PATH_BSR: next_r.bsr   = r.ring2;
                PATH_ID:  next_r.id_sh = ID_WORD;
                default:  next_r.byp   = 1'h0;
            endcase
        end
        // the ring stage reaches the preload latches only at data update
        if (next_r.st == ST_UPD_DR && path_of(r.ir) == PATH_BSR) begin
            next_r.pre = r.bsr;
        end
        // logic reset: identify, bus cell cleared
        if (next_r.st == ST_TLR) begin
            next_r.ir           = IR_IDCODE;
            next_r.pre[OE_CELL] = 1'h0;
        end
        // power-up reset, memory side untouched
        // placed after the walks, so it overrides every walk above; reset_in
        // arrives through two test-clock flops, so tck must run during it
        if (r.rst2) begin
            next_r.st    = ST_TLR;
            next_r.ir    = IR_IDCODE;
            next_r.ir_sh = IR_IDCODE;
            next_r.byp   = 1'h0;
            next_r.id_sh = '0;
            next_r.bsr   = '0;
            next_r.pre   = '0;
        end
        // bus controls, registered so the crossing sees no glitch
        next_r.ext = (next_r.ir == IR_EXTEST);
        next_r.hiz = (next_r.ir == IR_SAMPLEZ)
                   || (next_r.ext && !next_r.pre[OE_CELL]);
    end

    // all test-side state in r moves on rising test clock only
    always_ff @(posedge tck_in) begin
        r <= next_r;
    end

    // ------------------------------------------------------------------
    // serial data out, falling edge
    // ------------------------------------------------------------------
    // lsb of the chosen data path
    always_comb begin
        case (path_of(r.ir))
            PATH_BSR: dr_bit = r.bsr[0];
            PATH_ID:  dr_bit = r.id_sh[0];
            default:  dr_bit = r.byp;
        endcase
    end

    // a separate falling-edge flop: half a test clock of hold for
    // the tester, at the cost of a second edge in this domain
    always_ff @(negedge tck_in) begin
        if (r.rst2) begin
            tdo_q <= 1'h1;
            oe_q  <= 1'h0;
        end else begin
            oe_q  <= (r.st == ST_SH_DR) || (r.st == ST_SH_IR);
            tdo_q <= (r.st == ST_SH_IR) ? r.ir_sh[0] : dr_bit;
        end
    end

    // the pad floats tdo whenever the enable is low; tdo_q then still
    // follows dr_bit, or sits high in reset, which nobody outside should read
    assign tdo_out    = tdo_q;
    assign tdo_oe_out = oe_q;
    assign ring_out   = r.pre;

    // ------------------------------------------------------------------
    // memory-clock side: bus control crossing
    // ------------------------------------------------------------------
    // two independent levels, each through two flops; a brief skew
    // between them only delays the bus change by one memory clock
    always_comb begin
        next_s      = s;
        next_s.s1   = {r.ext, r.hiz};
        next_s.s2   = s.s1;
        next_s.ext  = s.s2[1];
        next_s.q_oe = !s.s2[0];
        if (reset_in) begin
            next_s.s1   = 2'h0;
            next_s.s2   = 2'h0;
            next_s.ext  = 1'h0;
            next_s.q_oe = 1'h1;
        end
    end

    // memory-clock registers
    // the bus stays enabled through reset so normal reads never wait
    // on the test port
    always_ff @(posedge clock_in) begin
        s <= next_s;
    end

    assign extest_out   = s.ext;
    assign q_bus_oe_out = s.q_oe;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // test-side checks but tdo_reset_a rest while the synchronised reset stands; the
    // memory-clock checks use reset_in, which resets their flops
    // five high mode-select rises reach home from anywhere
    five_ones_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        tms_in [*5] |=> (r.st == ST_TLR))
        else $error("five high tms did not reach reset");

    // home state always holds identify and a cleared bus cell
    reset_ident_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_TLR) |-> (r.ir == IR_IDCODE && !r.pre[OE_CELL]))
        else $error("reset state without identify or cleared cell");

    // fault-isolation pattern in the two low bits
    cap_ir_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_CAP_IR) |-> (r.ir_sh[1:0] == IR_CAPTURE[1:0]))
        else $error("instruction capture pattern wrong");

    // the shifted code becomes active on the way into update
    upd_ir_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_EX1_IR && tms_in) |=> (r.ir == $past(r.ir_sh)))
        else $error("instruction not taken at update");

    // the active code never moves during shifting
    ir_hold_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        $changed(r.ir) |-> (r.st == ST_UPD_IR || r.st == ST_TLR))
        else $error("instruction changed outside update");

    // the enable seen at a rise was set at the fall after the rise
    // into the present state, hence a same-cycle implication
    tdo_drive_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_SH_DR || r.st == ST_SH_IR) |-> oe_q)
        else $error("data out not driven while shifting");

    tdo_float_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        !(r.st == ST_SH_DR || r.st == ST_SH_IR) |-> !oe_q)
        else $error("data out driven outside shift");

    // bypass cell starts every scan at zero
    byp_cap_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_CAP_DR && path_of(r.ir) == PATH_BYP) |-> !r.byp)
        else $error("bypass did not capture zero");

    // identify scan starts from the fixed word
    id_cap_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_CAP_DR && r.ir == IR_IDCODE) |-> (r.id_sh == ID_WORD))
        else $error("identify word not captured");

    // ring stage: msb in, lsb out, one place per rise
    ring_shift_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_SH_DR && path_of(r.ir) == PATH_BSR)
        |=> (r.bsr == {$past(tdi_in), $past(r.bsr[BSR_W-1:1])}))
        else $error("ring shift wrong");

    // bus-off flag follows sample-z and the cleared cell under drive
    hiz_force_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.ir == IR_SAMPLEZ || (r.ext && !r.pre[OE_CELL])) |-> r.hiz)
        else $error("bus not forced off");

    // a settled bus-off level keeps the output bus disabled
    bus_off_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (s.s2[0] && $past(s.s2[0])) |-> !q_bus_oe_out)
        else $error("bus enabled while forced off");

    // the idle ring keeps still while another path is in the chain
    path_one_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_SH_DR && path_of(r.ir) != PATH_BSR) |=> $stable(r.bsr))
        else $error("ring moved while another path shifted");

    // instruction stage: msb in, lsb out
    ir_shift_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_SH_IR) |=> (r.ir_sh == {$past(tdi_in), $past(r.ir_sh[IR_W-1:1])}))
        else $error("instruction shift wrong");

    // bypass passes data in after one rise
    byp_shift_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_SH_DR && path_of(r.ir) == PATH_BYP) |=> (r.byp == $past(tdi_in)))
        else $error("bypass shift wrong");

    // ring capture takes the synchronised pin values
    ring_cap_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.st == ST_CAP_DR && path_of(r.ir) == PATH_BSR) |-> (r.bsr == $past(r.ring2)))
        else $error("ring capture wrong");

    // preload latches move only at data update or home
    pre_hold_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        $changed(r.pre) |-> (r.st == ST_UPD_DR || r.st == ST_TLR))
        else $error("preload moved outside update");

    // a set bus cell under external test lets the bus drive
    bus_cell_a: assert property (@(posedge tck_in) disable iff (r.rst2)
        (r.ir == IR_EXTEST && r.pre[OE_CELL]) |-> !r.hiz)
        else $error("bus forced off with cell set");

    // data out stays undriven through a standing reset
    tdo_reset_a: assert property (@(posedge tck_in)
        (r.rst2 && $past(r.rst2)) |-> !tdo_oe_out)
        else $error("data out driven in reset");

    // a settled external-test level reaches the pads
    ext_bus_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (s.s2[1] && $past(s.s2[1])) |-> extest_out)
        else $error("external test not passed on");

    id_shift_c: cover property (@(posedge tck_in) disable iff (r.rst2)
        r.ir == IR_IDCODE && r.st == ST_SH_DR);
    samplez_c: cover property (@(posedge tck_in) disable iff (r.rst2)
        r.st == ST_UPD_IR && r.ir == IR_SAMPLEZ);
    extest_on_c: cover property (@(posedge clock_in) disable iff (reset_in)
        extest_out && q_bus_oe_out);
    tms_reset_c: cover property (@(posedge tck_in) disable iff (r.rst2)
        r.st == ST_SH_DR ##1 tms_in [*5] ##1 r.st == ST_TLR);
    bypass_c: cover property (@(posedge tck_in) disable iff (r.rst2)
        r.st == ST_SH_DR && path_of(r.ir) == PATH_BYP);

endmodule : sbt_tap
